/* File: pkg/bpac_consts.svh */
`ifndef BPAC_CONSTS_SVH
`define BPAC_CONSTS_SVH

// Register byte offsets
`define BPAC_ADDR_CTRL      8'h00
`define BPAC_ADDR_IRQ_STAT  8'h04
`define BPAC_ADDR_IRQ_MASK  8'h08
`define BPAC_ADDR_ROW       8'h0c
`define BPAC_ADDR_COL       8'h10
`define BPAC_ADDR_PATTERN   8'h14

// Control and status field positions
`define BPAC_FP_HI          16
`define BPAC_FP_LO          15
`define BPAC_ACK_BIT        14
`define BPAC_STATE_HI       13
`define BPAC_STATE_LO       12
`define BPAC_TEN_BIT        11
`define BPAC_DIR_BIT        10
`define BPAC_ORDER_BIT      9
`define BPAC_TF_BIT         7

// Reset values
`define BPAC_FP_RST         2'h0
`define BPAC_DIR_RST        1'h0
`define BPAC_ORDER_RST      1'h0

// Fixed pattern encodings and base patterns
`define BPAC_FP_ONES        2'h0
`define BPAC_FP_ALT         2'h1
`define BPAC_FP_CHECK       2'h2
`define BPAC_PAT_ONES       8'hff
`define BPAC_PAT_ALT        8'haa
`define BPAC_PAT_CHECK      8'ha5
`define BPAC_PAT_W          8

// Instruction data source that selects the fixed pattern
`define BPAC_DSRC_FIXED     2'h2

// Interrupt event bits
`define BPAC_EV_FAIL        0
`define BPAC_EV_WRAP        1
`define BPAC_EV_N           2

`endif

/* File: pkg/bpac_pkg.sv */
package bpac_pkg;

  // Controller state, encodings 0 Initial, 1 Run, 2 Suspended
  typedef enum logic [1:0] {
    BPAC_ST_INIT,
    BPAC_ST_RUN,
    BPAC_ST_SUSP
  } bpac_ctl_e;

  // Fields of the executing instruction seen by this block
  typedef struct packed {
    logic [1:0] data_source_select;
    logic       data_polarity_invert;
    logic       update_address_flag;
  } bpac_instr_s;

  // Software register port
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bpac_reg_req_s;

  // Controller sequencing commands
  typedef struct packed {
    logic start;
    logic suspend;
    logic resume;
    logic stop;
  } bpac_ctl_cmd_s;

endpackage

/* File: design/bpac_top.sv */
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`include "bpac_consts.svh"

module bpac_top #(
  parameter int DW    = 32,
  parameter int ROW_W = 16,
  parameter int COL_W = 16
) (
  input  wire logic                   clk_i,
  input  wire logic                   srst_i,
  input  wire bpac_pkg::bpac_reg_req_s reg_req_i,
  output logic [31:0]                 reg_rdata_o,
  input  wire logic                   test_enable_i,
  input  wire logic                   bist_ack_input_i,
  input  wire bpac_pkg::bpac_ctl_cmd_s ctl_cmd_i,
  input  wire logic                   exec_i,
  input  wire bpac_pkg::bpac_instr_s  instr_i,
  input  wire logic [DW-1:0]          instr_data_i,
  input  wire logic                   cmp_i,
  input  wire logic [DW-1:0]          rd_data_i,
  output logic [DW-1:0]               mem_wdata_o,
  output logic [DW-1:0]               mem_expect_o,
  output logic [ROW_W-1:0]            row_index_o,
  output logic [COL_W-1:0]            column_index_o,
  output logic                        test_failed_o,
  output logic [1:0]                  ctl_state_o,
  output logic                        irq_o
);

  typedef struct packed {
    logic                    ten_s1;
    logic                    ten_s2;
    logic                    ack_s1;
    logic                    ack_s2;
    logic [1:0]              fp;
    logic                    dir;
    logic                    order;
    logic                    tf;
    bpac_pkg::bpac_ctl_e     ctl;
    logic [`BPAC_EV_N-1:0]   irq_stat;
    logic [`BPAC_EV_N-1:0]   irq_mask;
    logic [ROW_W-1:0]        row;
    logic [COL_W-1:0]        col;
    logic [DW-1:0]           wdata;
    logic [DW-1:0]           expect_d;
    logic [31:0]             rdata;
    logic                    irq;
  } bpac_state_s;

  bpac_state_s state_ff;
  bpac_state_s nxt_state;

  // Base pattern for a select code
  function automatic logic [`BPAC_PAT_W-1:0] bpac_base_pat(input logic [1:0] sel);
    logic [`BPAC_PAT_W-1:0] p;
    p = `BPAC_PAT_ONES;
    // reserved code falls back to all ones
    if (sel == `BPAC_FP_ALT) begin
      p = `BPAC_PAT_ALT;
    end else if (sel == `BPAC_FP_CHECK) begin
      p = `BPAC_PAT_CHECK;
    end
    return p;
  endfunction

  // One step of a row or column index
  function automatic logic [31:0] bpac_step(input logic [31:0] v, input logic up);
    logic [31:0] r;
    r = up ? v + 32'h1 : v - 32'h1;
    return r;
  endfunction

  // Index sits at the last value for the current direction
  function automatic logic bpac_at_end(input logic [31:0] v, input int w, input logic up);
    logic [31:0] lim;
    lim = up ? ((32'h1 << w) - 32'h1) : 32'h0;
    return v == lim;
  endfunction

  logic [`BPAC_PAT_W-1:0] base_pat;
  logic [DW-1:0]          rep_pat;

  // pattern chosen by the select field
  assign base_pat = bpac_base_pat(state_ff.fp);

  for (genvar gi = 0; gi < DW; gi++) begin : g_rep
    assign rep_pat[gi] = base_pat[gi % `BPAC_PAT_W];
  end

  logic        test_enable_mirror;
  logic        wr_ok;
  logic        row_end;
  logic        col_end;
  logic [31:0] row_wide;
  logic [31:0] col_wide;
  logic [31:0] row_nx;
  logic [31:0] col_nx;
  logic [DW-1:0] src_data;
  logic        fixed_sel;
  logic        mismatch;
  logic [`BPAC_EV_N-1:0] ev;
  logic [`BPAC_EV_N-1:0] clr;
  logic [31:0] ctrl_word;

  assign test_enable_mirror      = state_ff.ten_s2;
  // writes ignored while test enable is low
  assign wr_ok    = reg_req_i.wr && test_enable_mirror;
  assign row_wide = 32'(state_ff.row);
  assign col_wide = 32'(state_ff.col);
  assign row_end  = bpac_at_end(row_wide, ROW_W, state_ff.dir);
  assign col_end  = bpac_at_end(col_wide, COL_W, state_ff.dir);
  assign row_nx   = bpac_step(row_wide, state_ff.dir);
  assign col_nx   = bpac_step(col_wide, state_ff.dir);

  // fixed pattern only for data source 2'b10
  assign fixed_sel = instr_i.data_source_select == `BPAC_DSRC_FIXED;
  // polarity inversion applies to the source data
  assign src_data  = (fixed_sel ? rep_pat : instr_data_i)
                     ^ {DW{instr_i.data_polarity_invert}};

  // Compare read data against the expected word of the last instruction
  assign mismatch = cmp_i && (rd_data_i != state_ff.expect_d)
                    && (state_ff.ctl == bpac_pkg::BPAC_ST_RUN);

  // Control and status word as seen by software
  always_comb begin
    ctrl_word = 32'h0;
    ctrl_word[`BPAC_FP_HI:`BPAC_FP_LO] = state_ff.fp;
    ctrl_word[`BPAC_ACK_BIT] = state_ff.ack_s2;
    ctrl_word[`BPAC_STATE_HI:`BPAC_STATE_LO] = 2'(state_ff.ctl);
    ctrl_word[`BPAC_TEN_BIT] = test_enable_mirror;
    ctrl_word[`BPAC_DIR_BIT] = state_ff.dir;
    ctrl_word[`BPAC_ORDER_BIT] = state_ff.order;
    ctrl_word[`BPAC_TF_BIT] = state_ff.tf;
  end

  always_comb begin
    nxt_state = state_ff;
    ev  = '0;
    clr = '0;

    // Pins cross into the clock domain through two flops
    nxt_state.ten_s1 = test_enable_i;
    nxt_state.ten_s2 = state_ff.ten_s1;
    nxt_state.ack_s1 = bist_ack_input_i;
    nxt_state.ack_s2 = state_ff.ack_s1;

    // Controller sequencing, forced back to Initial while disabled
    if (!test_enable_mirror || ctl_cmd_i.stop) begin
      nxt_state.ctl = bpac_pkg::BPAC_ST_INIT;
    end else begin
      case (state_ff.ctl)
        bpac_pkg::BPAC_ST_INIT: begin
          if (ctl_cmd_i.start) begin
            nxt_state.ctl = bpac_pkg::BPAC_ST_RUN;
          end
        end
        bpac_pkg::BPAC_ST_RUN: begin
          if (ctl_cmd_i.suspend) begin
            nxt_state.ctl = bpac_pkg::BPAC_ST_SUSP;
          end
        end
        bpac_pkg::BPAC_ST_SUSP: begin
          if (ctl_cmd_i.resume) begin
            nxt_state.ctl = bpac_pkg::BPAC_ST_RUN;
          end
        end
        default: begin
          nxt_state.ctl = bpac_pkg::BPAC_ST_INIT;
        end
      endcase
    end

    // Software writes, applied before hardware so hardware wins
    if (wr_ok) begin
      if (reg_req_i.addr == `BPAC_ADDR_CTRL) begin
        nxt_state.fp = reg_req_i.wdata[`BPAC_FP_HI:`BPAC_FP_LO];
        nxt_state.dir = reg_req_i.wdata[`BPAC_DIR_BIT];
        nxt_state.order = reg_req_i.wdata[`BPAC_ORDER_BIT];
        // only software clears the fail flag
        nxt_state.tf = reg_req_i.wdata[`BPAC_TF_BIT];
      end else if (reg_req_i.addr == `BPAC_ADDR_IRQ_STAT) begin
        clr = reg_req_i.wdata[`BPAC_EV_N-1:0];
      end else if (reg_req_i.addr == `BPAC_ADDR_IRQ_MASK) begin
        nxt_state.irq_mask = reg_req_i.wdata[`BPAC_EV_N-1:0];
      end else if (reg_req_i.addr == `BPAC_ADDR_ROW) begin
        nxt_state.row = reg_req_i.wdata[ROW_W-1:0];
      end else if (reg_req_i.addr == `BPAC_ADDR_COL) begin
        nxt_state.col = reg_req_i.wdata[COL_W-1:0];
      end
    end

    // Instruction execution, only while running and enabled
    if (exec_i && test_enable_mirror && state_ff.ctl == bpac_pkg::BPAC_ST_RUN) begin
      nxt_state.wdata    = src_data;
      nxt_state.expect_d = src_data;
      if (instr_i.update_address_flag) begin
        if (!state_ff.order) begin
          // column fast, row follows a column wrap
          nxt_state.col = col_nx[COL_W-1:0];
          if (col_end) begin
            nxt_state.row = row_nx[ROW_W-1:0];
          end
        end else begin
          // row fast, column follows a row wrap
          nxt_state.row = row_nx[ROW_W-1:0];
          if (row_end) begin
            nxt_state.col = col_nx[COL_W-1:0];
          end
        end
        ev[`BPAC_EV_WRAP] = row_end && col_end;
      end
    end

    // a failed comparison sets the flag, set wins over a clear
    if (mismatch) begin
      nxt_state.tf = 1'b1;
      ev[`BPAC_EV_FAIL] = 1'b1;
    end

    // Sticky events, a new event beats a same-cycle clear
    nxt_state.irq_stat = (state_ff.irq_stat & ~clr) | ev;
    nxt_state.irq = |(nxt_state.irq_stat & nxt_state.irq_mask);

    // Read data valid in the cycle after the strobe only
    nxt_state.rdata = 32'h0;
    if (reg_req_i.rd) begin
      if (reg_req_i.addr == `BPAC_ADDR_CTRL) begin
        nxt_state.rdata = ctrl_word;
      end else if (reg_req_i.addr == `BPAC_ADDR_IRQ_STAT) begin
        nxt_state.rdata = 32'(state_ff.irq_stat);
      end else if (reg_req_i.addr == `BPAC_ADDR_IRQ_MASK) begin
        nxt_state.rdata = 32'(state_ff.irq_mask);
      end else if (reg_req_i.addr == `BPAC_ADDR_ROW) begin
        nxt_state.rdata = row_wide;
      end else if (reg_req_i.addr == `BPAC_ADDR_COL) begin
        nxt_state.rdata = col_wide;
      end else if (reg_req_i.addr == `BPAC_ADDR_PATTERN) begin
        nxt_state.rdata = 32'(base_pat);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_ff          <= '0;
      state_ff.fp       <= `BPAC_FP_RST;
      state_ff.dir      <= `BPAC_DIR_RST;
      state_ff.order    <= `BPAC_ORDER_RST;
      state_ff.ctl      <= bpac_pkg::BPAC_ST_INIT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign reg_rdata_o    = state_ff.rdata;
  assign mem_wdata_o    = state_ff.wdata;
  assign mem_expect_o   = state_ff.expect_d;
  assign row_index_o    = state_ff.row;
  assign column_index_o = state_ff.col;
  assign test_failed_o  = state_ff.tf;
  assign ctl_state_o    = 2'(state_ff.ctl);
  assign irq_o          = state_ff.irq;

endmodule

/* File: tb/bpac_top_assertions.sv */
`timescale 1ns/10ps
module bpac_chk #(
  parameter int DW    = 32,
  parameter int ROW_W = 16,
  parameter int COL_W = 16
) (
  input wire logic                    clk_i,
  input wire logic                    srst_i,
  input wire bpac_pkg::bpac_reg_req_s reg_req_i,
  input wire logic                    test_enable_i,
  input wire bpac_pkg::bpac_ctl_cmd_s ctl_cmd_i,
  input wire logic                    exec_i,
  input wire bpac_pkg::bpac_instr_s   instr_i,
  input wire logic [DW-1:0]           instr_data_i,
  input wire logic                    cmp_i,
  input wire logic [DW-1:0]           rd_data_i,
  input wire logic [DW-1:0]           mem_wdata_o,
  input wire logic [DW-1:0]           mem_expect_o,
  input wire logic [ROW_W-1:0]        row_index_o,
  input wire logic [COL_W-1:0]        column_index_o,
  input wire logic                    test_failed_o,
  input wire logic [1:0]              ctl_state_o
);
  // Mirrors the two-flop enable sync so checks see what the block sees
  logic [1:0] ten_ff;
  logic       run;
  always_ff @(posedge clk_i) ten_ff <= srst_i ? 2'h0 : {ten_ff[0], test_enable_i};
  assign run = ten_ff[1] && ctl_state_o == 2'h1;
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  chk_fail_sets:
    assert property (cmp_i && run && rd_data_i != mem_expect_o |=> test_failed_o)
      else $error("compare miss left fail flag low");
  chk_fail_sticky:
    assert property (test_failed_o && !reg_req_i.wr |=> test_failed_o)
      else $error("fail flag dropped without a write");
  chk_src_data:
    assert property (exec_i && run && instr_i.data_source_select != 2'h2 |=>
      mem_wdata_o == ($past(instr_data_i) ^ {DW{$past(instr_i.data_polarity_invert)}}))
      else $error("non-fixed write data wrong");
  chk_expect_same:
    assert property (exec_i && run |=> mem_expect_o == mem_wdata_o)
      else $error("expected data differs from write data");
  chk_addr_hold:
    assert property (!(exec_i && instr_i.update_address_flag) && !reg_req_i.wr |=>
      $stable(row_index_o) && $stable(column_index_o))
      else $error("address moved without update");
  chk_addr_step:
    assert property (exec_i && run && instr_i.update_address_flag |=>
      row_index_o != $past(row_index_o) || column_index_o != $past(column_index_o))
      else $error("address update did not step");
  chk_start_run:
    assert property (ten_ff[1] && ctl_state_o == 2'h0 && ctl_cmd_i.start && !ctl_cmd_i.stop
      |=> ctl_state_o == 2'h1)
      else $error("start did not reach run");
  chk_state_legal:
    assert property (ctl_state_o != 2'h3)
      else $error("reserved state code");
  chk_ten_init:
    assert property (!ten_ff[1] |=> ctl_state_o == 2'h0)
      else $error("disabled controller not initial");
endmodule

bind bpac_top bpac_chk #(.DW(DW), .ROW_W(ROW_W), .COL_W(COL_W)) u_chk (
  .clk_i(clk_i), .srst_i(srst_i), .reg_req_i(reg_req_i), .test_enable_i(test_enable_i),
  .ctl_cmd_i(ctl_cmd_i), .exec_i(exec_i), .instr_i(instr_i), .instr_data_i(instr_data_i),
  .cmp_i(cmp_i), .rd_data_i(rd_data_i), .mem_wdata_o(mem_wdata_o),
  .mem_expect_o(mem_expect_o), .row_index_o(row_index_o),
  .column_index_o(column_index_o), .test_failed_o(test_failed_o),
  .ctl_state_o(ctl_state_o));

/* File: tb/bpac_mem_model.sv */
`timescale 1ns/10ps
module bpac_mem_model #(
  parameter int DW = 32
) (
  input  wire logic          clk_i,
  input  wire logic          wr_i,
  input  wire logic          rd_i,
  input  wire logic          corrupt_i,
  input  wire logic [DW-1:0] wdata_i,
  output logic [DW-1:0]      rd_data_o,
  output logic               ack_o
);
  logic [DW-1:0] word_ff = '0;
  logic          ack_ff  = 1'b0;
  always @(posedge clk_i) begin
    if (wr_i) word_ff <= wdata_i;
    ack_ff <= wr_i || rd_i;
  end
  assign ack_o = ack_ff;
  // Idle bus shows the inverse so a stale word never passes a compare
  assign rd_data_o = rd_i ? word_ff ^ DW'(corrupt_i) : ~word_ff;
endmodule

/* File: tb/bist_pattern_address_control_tb.sv */
`timescale 1ns/10ps
module bist_pattern_address_control_tb;
  localparam int RW = 2;
  logic clk_i = 1'b0, srst_i = 1'b1, test_enable_mirror = 1'b1, exec = 1'b0, cmp = 1'b0, mwr = 1'b0;
  logic bad = 1'b0, tf, irq, ack;
  bpac_pkg::bpac_reg_req_s req = '0;
  bpac_pkg::bpac_ctl_cmd_s cmd = '0;
  bpac_pkg::bpac_instr_s   ins = '0;
  logic [31:0] idat = '0, rdata, wdat, expd, rdd;
  logic [RW-1:0] row, col;
  logic [1:0] st;
  int fails = 0, checked = 0;
  always #25 clk_i = ~clk_i;
  bpac_top #(.DW(32), .ROW_W(RW), .COL_W(RW)) u_dut (.clk_i(clk_i), .srst_i(srst_i),
    .reg_req_i(req), .reg_rdata_o(rdata), .test_enable_i(test_enable_mirror), .bist_ack_input_i(ack),
    .ctl_cmd_i(cmd), .exec_i(exec), .instr_i(ins), .instr_data_i(idat), .cmp_i(cmp),
    .rd_data_i(rdd), .mem_wdata_o(wdat), .mem_expect_o(expd), .row_index_o(row),
    .column_index_o(col), .test_failed_o(tf), .ctl_state_o(st), .irq_o(irq));
  bpac_mem_model #(.DW(32)) u_mem (.clk_i(clk_i), .wr_i(mwr), .rd_i(cmp), .corrupt_i(bad),
    .wdata_i(wdat), .rd_data_o(rdd), .ack_o(ack));
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk_i);
    req <= {a, d, 2'b10};
    @(posedge clk_i);
    req <= '0;
  endtask
  task automatic rc(logic [7:0] a, logic [31:0] e, string n);
    @(posedge clk_i);
    req <= {a, 32'h0, 2'b01};
    @(posedge clk_i);
    req <= '0;
    #1;
    chk(n, e, rdata);
  endtask
  task automatic ex(logic [1:0] s, logic p, logic u, logic [31:0] d);
    @(posedge clk_i);
    exec <= 1'b1;
    ins <= {s, p, u};
    idat <= d;
    @(posedge clk_i);
    exec <= 1'b0;
    mwr <= 1'b1;
    @(posedge clk_i);
    mwr <= 1'b0;
    #1;
  endtask
  task automatic cm(logic [3:0] c, logic [1:0] e);
    @(posedge clk_i);
    cmd <= c;
    @(posedge clk_i);
    cmd <= '0;
    #1;
    chk("state", 32'(e), 32'(st));
  endtask
  task automatic cp(logic b, logic e);
    @(posedge clk_i);
    cmp <= 1'b1;
    bad <= b;
    @(posedge clk_i);
    cmp <= 1'b0;
    bad <= 1'b0;
    #1;
    chk("tf", 32'(e), 32'(tf));
  endtask
  task automatic t_reset;
    rc(8'h00, 32'h800, "ctrl");
    rc(8'h3c, 32'h0, "unmapped");
    $display("t_reset done");
  endtask
  task automatic t_pattern;
    logic [7:0] base [3] = '{8'hff, 8'haa, 8'ha5};
    cm(4'b1000, 2'h1);
    // Reserved code 3 is never written
    for (int f = 0; f < 3; f++) begin
      wr(8'h00, 32'(f) << 15);
      rc(8'h14, {24'h0, base[f]}, "base");
      ex(2'h2, f[0], 1'b0, 32'h0);
      chk("wdata", {4{base[f]}} ^ {32{f[0]}}, wdat);
    end
    ex(2'h1, 1'b1, 1'b0, 32'h1234_5678);
    chk("wdata", 32'hedcb_a987, wdat);
    // Acknowledge pulse from the write needs two sync stages before it shows
    @(posedge clk_i);
    rc(8'h00, 32'h0001_5800, "ctrl");
    $display("t_pattern done");
  endtask
  task automatic t_addr;
    wr(8'h00, 32'h400);
    wr(8'h0c, 32'h0);
    wr(8'h10, 32'h3);
    ex(2'h0, 1'b0, 1'b1, 32'h0);
    chk("rowcol", 32'h4, 32'({row, col}));
    ex(2'h0, 1'b0, 1'b0, 32'h0);
    chk("rowcol", 32'h4, 32'({row, col}));
    wr(8'h00, 32'h200);
    wr(8'h10, 32'h2);
    wr(8'h0c, 32'h0);
    ex(2'h0, 1'b0, 1'b1, 32'h0);
    chk("rowcol", 32'hd, 32'({row, col}));
    ex(2'h0, 1'b0, 1'b1, 32'h0);
    chk("rowcol", 32'h9, 32'({row, col}));
    cm(4'b0100, 2'h2);
    ex(2'h0, 1'b0, 1'b1, 32'h0);
    chk("rowcol", 32'h9, 32'({row, col}));
    cm(4'b0010, 2'h1);
    $display("t_addr done");
  endtask
  task automatic t_fail;
    wr(8'h08, 32'h1);
    ex(2'h2, 1'b0, 1'b0, 32'h0);
    cp(1'b0, 1'b0);
    cp(1'b1, 1'b1);
    chk("irq", 32'h1, 32'(irq));
    rc(8'h04, 32'h1, "stat");
    wr(8'h04, 32'h1);
    rc(8'h04, 32'h0, "stat");
    chk("irq", 32'h0, 32'(irq));
    chk("tf", 32'h1, 32'(tf));
    wr(8'h00, 32'h0);
    rc(8'h00, 32'h1800, "ctrl");
    wr(8'h08, 32'h0);
    cp(1'b1, 1'b1);
    chk("irq", 32'h0, 32'(irq));
    $display("t_fail done");
  endtask
  task automatic t_ten;
    @(posedge clk_i);
    test_enable_mirror <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    chk("state", 32'h0, 32'(st));
    wr(8'h0c, 32'h1);
    rc(8'h0c, 32'h2, "row");
    rc(8'h00, 32'h80, "ctrl");
    @(posedge clk_i);
    test_enable_mirror <= 1'b1;
    $display("t_ten done");
  endtask
  task automatic end_of_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    t_reset;
    t_pattern;
    t_addr;
    t_fail;
    t_ten;
    end_of_test;
  end
  initial begin
    repeat (2000) @(posedge clk_i);
    fails++;
    end_of_test;
  end
endmodule
